// ===== tscd_checker_assertions.sv
// port checker of the trigger step command decoder
// assumes binding to tscd_top, one clock domain
`timescale 1ns/100ps
module tscd_checker (
    // clock and reset
    input wire logic SYS_CLK_I,
    input wire logic RST_B_I,
    // register port
    input wire logic [5:0] ADDR_I,
    input wire logic [15:0] WDATA_I,
    input wire logic WR_I,
    input wire logic RD_I,
    input wire logic [15:0] RDATA_O,
    // step outputs
    input wire logic [31:0] TRIG_OUT_O,
    input wire logic [15:0] INT_REQ_O,
    input wire logic IRQ_O,
    input wire logic [4:0] CHAN_SEL_O
);
    default clocking @(posedge SYS_CLK_I); endclocking
    default disable iff (!RST_B_I);

    ////////////////////////////////////////////////////////////////////////////
    sequence s_rd_chsel;
        RD_I && ADDR_I == tscd_pkg::REG_CHSEL;
    endsequence

    // queue entry written, then read back two cycles later
    property p_queue_back;
        logic [7:0] wd;
        logic [5:0] ad;
        (WR_I && ADDR_I[5], wd = WDATA_I[7:0], ad = ADDR_I) ##1 !(WR_I && ADDR_I == ad)
            ##1 (RD_I && ADDR_I == ad) |=> RDATA_O[7:0] == wd;
    endproperty

    ////////////////////////////////////////////////////////////////////////////
    a_trig_onehot: assert property ($onehot0(TRIG_OUT_O))
        else $error("several trigger outputs at once");
    a_trig_req_excl: assert property (!(|TRIG_OUT_O && |INT_REQ_O))
        else $error("trigger and request from one step");
    a_req_onehot: assert property ($onehot0(INT_REQ_O))
        else $error("several interrupt requests at once");
    a_chsel_step: assert property ($changed(CHAN_SEL_O) |-> $past(WR_I) ||
        (TRIG_OUT_O == 32'h0 && INT_REQ_O == 16'h0))
        else $error("channel select moved beside another step");
    a_irq_rise_cause: assert property ($rose(IRQ_O) |-> INT_REQ_O != 16'h0 ||
        $past(INT_REQ_O) != 16'h0 || $past(WR_I) || $past(WR_I, 2))
        else $error("interrupt rose without request or write");
    a_irq_fall_cause: assert property ($fell(IRQ_O) |-> $past(WR_I) || $past(WR_I, 2))
        else $error("interrupt fell without a write");
    a_queue_readback: assert property (p_queue_back)
        else $error("step byte read back differs");
    a_chsel_readback: assert property (s_rd_chsel |=> RDATA_O[4:0] == $past(CHAN_SEL_O))
        else $error("channel select read differs from output");
endmodule

bind tscd_top tscd_checker tscd_checker_inst (.SYS_CLK_I, .RST_B_I, .ADDR_I, .WDATA_I,
    .WR_I, .RD_I, .RDATA_O, .TRIG_OUT_O, .INT_REQ_O, .IRQ_O, .CHAN_SEL_O);

// ===== tscd_edge_det.sv
// rising and falling edge detector for the trigger inputs
// assumes inputs synchronous to the clock
`timescale 1ns/100ps
module tscd_edge_det (
    // clock and reset
    input wire logic clk_i,
    input wire logic rst_b_i,
    // trigger levels and their edges
    input wire logic [15:0] trig_i,
    output tscd_pkg::tscd_edge_t edge_o
);
    logic [15:0] prev;
    logic [15:0] next_prev;

    assign next_prev = trig_i;

    always_ff @(posedge clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            prev <= 16'h0000;
        end else begin
            prev <= next_prev;
        end
    end

    genvar g;
    generate
        for (g = 0; g < 16; g++) begin : g_edge
            assign edge_o.rise[g] = trig_i[g] & ~prev[g];
            assign edge_o.fall[g] = ~trig_i[g] & prev[g];
        end
    endgenerate
endmodule

// ===== tscd_irq.sv
// sticky interrupt status, mask and level interrupt output
// assumes write strobes already decoded by the caller
`timescale 1ns/100ps
module tscd_irq (
    // clock and reset
    input wire logic clk_i,
    input wire logic rst_b_i,
    // events and software access
    input wire logic [15:0] set_i,
    input wire logic clr_wr_i,
    input wire logic mask_wr_i,
    input wire logic [15:0] wdata_i,
    // state
    output tscd_pkg::tscd_irq_t irq_o
);
    tscd_pkg::tscd_irq_t r;
    tscd_pkg::tscd_irq_t next_r;

    always_comb begin
        next_r = r;
        // set wins over a write-one clear in the same cycle
        if (clr_wr_i) begin
            next_r.status = r.status & ~wdata_i;
        end
        next_r.status = next_r.status | set_i;
        if (mask_wr_i) begin
            next_r.mask = wdata_i;
        end
        next_r.irq = |(next_r.status & next_r.mask);
    end

    always_ff @(posedge clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            r <= '0;
        end else begin
            r <= next_r;
        end
    end

    assign irq_o = r;
endmodule

// ===== tscd_periph_model.sv
// trigger sources and sinks beside the step decoder
// assumes one clock; the bench moves levels through set_level
`timescale 1ns/100ps
module tscd_periph_model (
    // clock and reset
    input wire logic clk_i,
    input wire logic rst_b_i,
    // outputs of the decoder
    input wire logic [31:0] trig_out_i,
    input wire logic [15:0] int_req_i,
    // trigger levels towards the decoder
    output logic [15:0] trig_in_o
);
    int trig_cnt [32];
    int int_cnt [16];

    initial trig_in_o = 16'h0000;

    // count pulses seen by the consumers
    always @(posedge clk_i) begin
        for (int i = 0; i < 32; i++) begin
            if (rst_b_i && trig_out_i[i] === 1'b1) trig_cnt[i]++;
        end
        for (int i = 0; i < 16; i++) begin
            if (rst_b_i && int_req_i[i] === 1'b1) int_cnt[i]++;
        end
    end

    // prompt with delay 0, slow otherwise
    task automatic set_level(input int sel, input logic lvl, input int delay);
        repeat (delay) @(posedge clk_i);
        trig_in_o[sel] <= lvl;
    endtask

    task automatic clear_counts();
        foreach (trig_cnt[i]) trig_cnt[i] = 0;
        foreach (int_cnt[i]) int_cnt[i] = 0;
    endtask
endmodule

// ===== tscd_pkg.sv
// constants, types and helpers of the trigger step command decoder
// assumes one system clock; software loads the step queue over the plain register port
//
// Behaviour
// - step byte: upper nibble is command code, lower nibble is option
// - code 0000 performs the control action chosen by the option
// - code 0001 adds adjust register, or copies hold register, into chosen target
// - codes 001x load five-bit converter channel select from command bit 0 and option
// - code 0100 stalls until a rising edge on the selected trigger input
// - code 0101 stalls until a falling edge on the selected trigger input
// - code 0110 and reserved options execute as no-operation steps
// - code 0111 raises the interrupt request chosen by the option
// - codes 100x pulse the trigger output chosen by the five-bit value
// - codes 101x load queue pointer with the five-bit value and continue there
// - codes 110x: counter 0 at limit advances, else counts up and jumps
// - codes 111x: counter 1 at limit advances, else counts up and jumps
package tscd_pkg;

    ////////////////////////////////////////////////////////////////////////////
    // register offsets (word index on the register port)
    localparam logic [5:0] REG_CTRL = 6'h00;
    localparam logic [5:0] REG_STAT = 6'h01;
    localparam logic [5:0] REG_ADJ = 6'h02;
    localparam logic [5:0] REG_HOLD = 6'h03;
    localparam logic [5:0] REG_LIM0 = 6'h04;
    localparam logic [5:0] REG_LIM1 = 6'h05;
    localparam logic [5:0] REG_CNT0 = 6'h06;
    localparam logic [5:0] REG_CNT1 = 6'h07;
    localparam logic [5:0] REG_CHSEL = 6'h08;
    localparam logic [5:0] REG_INT_STAT = 6'h09;
    localparam logic [5:0] REG_INT_MASK = 6'h0A;
    localparam int unsigned QUEUE_SEL_BIT = 5;

    // field positions
    localparam int unsigned CTRL_RUN_BIT = 0;
    localparam int unsigned CTRL_PTR_CLR_BIT = 1;
    localparam int unsigned STAT_BUSY_BIT = 0;
    localparam int unsigned STAT_WAIT_BIT = 1;
    localparam int unsigned STAT_PTR_LSB = 8;
    localparam int unsigned OPT_COPY_BIT = 3;

    // reset values
    localparam logic [15:0] RST_WORD = 16'h0000;
    localparam logic [7:0] RST_STEP = 8'h00;

    ////////////////////////////////////////////////////////////////////////////
    // command codes
    localparam logic [3:0] CMD_CTRL = 4'h0;
    localparam logic [3:0] CMD_ADD = 4'h1;
    localparam logic [3:0] CMD_WAIT_HI = 4'h4;
    localparam logic [3:0] CMD_WAIT_LO = 4'h5;
    localparam logic [3:0] CMD_RSVD = 4'h6;
    localparam logic [3:0] CMD_IRQ = 4'h7;
    localparam logic [2:0] GRP_STRB = 3'h1;
    localparam logic [2:0] GRP_TRIG = 3'h4;
    localparam logic [2:0] GRP_JMP = 3'h5;
    localparam logic [2:0] GRP_JC0 = 3'h6;
    localparam logic [2:0] GRP_JC1 = 3'h7;

    // control actions
    localparam logic [3:0] CTL_NOP = 4'h0;
    localparam logic [3:0] CTL_CLR_C0 = 4'h1;
    localparam logic [3:0] CTL_CLR_C1 = 4'h2;
    localparam logic [3:0] CTL_HALT = 4'h3;

    // add / copy targets
    localparam logic [2:0] TGT_LIM0 = 3'h0;
    localparam logic [2:0] TGT_LIM1 = 3'h1;
    localparam logic [2:0] TGT_CNT0 = 3'h2;
    localparam logic [2:0] TGT_CNT1 = 3'h3;

    ////////////////////////////////////////////////////////////////////////////
    typedef enum logic [1:0] {ST_IDLE, ST_EXEC, ST_WAIT} tscd_state_t;

    typedef struct packed {
        logic [15:0] rise;
        logic [15:0] fall;
    } tscd_edge_t;

    typedef struct packed {
        logic [15:0] status;
        logic [15:0] mask;
        logic irq;
    } tscd_irq_t;

    // five-bit target of a step: command bit 0 with the option
    function automatic logic [4:0] target5(input logic [7:0] step);
        return step[4:0];
    endfunction

endpackage

// ===== tscd_tb_top.sv
// self-checking bench of the trigger step command decoder
// assumes tscd_top, its bound checker and the peripheral model
`timescale 1ns/100ps
module tscd_tb_top;
    logic clk;
    logic rst_b;
    logic wr_en;
    logic rd_en;
    logic [5:0] addr;
    logic [15:0] wdata;
    logic [15:0] rdata;
    logic [15:0] trig_in;
    logic [31:0] trig_out;
    logic [15:0] int_req;
    logic irq;
    logic [4:0] chan_sel;
    int bad_count = 0;
    int check_count = 0;

    tscd_top tscd_top_inst (.SYS_CLK_I(clk), .RST_B_I(rst_b), .ADDR_I(addr), .WDATA_I(wdata),
        .WR_I(wr_en), .RD_I(rd_en), .RDATA_O(rdata), .TRIG_IN_I(trig_in),
        .TRIG_OUT_O(trig_out), .INT_REQ_O(int_req), .IRQ_O(irq), .CHAN_SEL_O(chan_sel));
    tscd_periph_model periph (.clk_i(clk), .rst_b_i(rst_b), .trig_out_i(trig_out),
        .int_req_i(int_req), .trig_in_o(trig_in));

    initial begin
        clk = 1'b0;
        forever #2.5 clk = ~clk;
    end

    ////////////////////////////////////////////////////////////////////////////
    task automatic give_verdict();
        if (bad_count == 0 && check_count > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask

    task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
        check_count++;
        if (got !== exp) begin
            bad_count++;
            $display("unexpected at %0t: %s got %0h want %0h", $time, what, got, exp);
        end
    endtask

    task automatic tick(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask

    task automatic wr(input logic [5:0] a, input logic [15:0] d);
        @(posedge clk);
        addr <= a;
        wdata <= d;
        wr_en <= 1'b1;
        @(posedge clk);
        wr_en <= 1'b0;
    endtask

    task automatic rchk(input logic [5:0] a, input logic [15:0] exp, input string what);
        @(posedge clk);
        addr <= a;
        rd_en <= 1'b1;
        @(posedge clk);
        rd_en <= 1'b0;
        #1;
        chk({16'h0000, rdata}, {16'h0000, exp}, what);
    endtask

    task automatic load(input logic [7:0] q [11]);
        foreach (q[i]) wr(6'h20 + 6'(i), {8'h00, q[i]});
        rchk(6'h2A, {8'h00, q[10]}, "queue entry");
    endtask

    // poll busy under a bound
    task automatic wait_idle();
        logic busy;
        busy = 1'b1;
        for (int n = 0; n < 100 && busy; n++) begin
            @(posedge clk);
            addr <= tscd_pkg::REG_STAT;
            rd_en <= 1'b1;
            @(posedge clk);
            rd_en <= 1'b0;
            #1;
            busy = rdata[tscd_pkg::STAT_BUSY_BIT] !== 1'b0;
        end
        if (busy) begin
            bad_count++;
            $display("unexpected at %0t: sequencer never idle", $time);
            give_verdict();
        end
    endtask

    ////////////////////////////////////////////////////////////////////////////
    task automatic test_actions();
        logic [7:0] prog [11] = '{8'h2A, 8'h35, 8'h83, 8'h91, 8'h75, 8'h60, 8'h12, 8'h19,
            8'hAA, 8'h84, 8'h03};
        wr(tscd_pkg::REG_ADJ, 16'h0003);
        wr(tscd_pkg::REG_HOLD, 16'h0007);
        load(prog);
        wr(tscd_pkg::REG_CTRL, 16'h0001);
        tick(3);
        wait_idle();
        chk(32'(chan_sel), 32'h15, "channel select");
        rchk(tscd_pkg::REG_CHSEL, 16'h0015, "channel select read");
        chk(periph.trig_cnt[3], 32'h1, "trigger 3");
        chk(periph.trig_cnt[17], 32'h1, "trigger 17");
        chk(periph.trig_cnt[4], 32'h0, "skipped trigger 4");
        chk(periph.int_cnt[5], 32'h1, "request 5");
        rchk(tscd_pkg::REG_CNT0, 16'h0003, "add into counter 0");
        rchk(tscd_pkg::REG_LIM1, 16'h0007, "copy into limit 1");
        rchk(tscd_pkg::REG_STAT, 16'h0B00, "pointer after halt");
    endtask

    task automatic test_irq();
        chk({31'h0, irq}, 32'h0, "masked interrupt");
        rchk(tscd_pkg::REG_INT_STAT, 16'h0020, "sticky status");
        wr(tscd_pkg::REG_INT_MASK, 16'h0020);
        tick(2);
        chk({31'h0, irq}, 32'h1, "unmasked interrupt");
        wr(tscd_pkg::REG_INT_STAT, 16'h0020);
        tick(2);
        chk({31'h0, irq}, 32'h0, "cleared interrupt");
        rchk(tscd_pkg::REG_INT_STAT, 16'h0000, "status cleared");
        rchk(6'h1F, 16'h0000, "unmapped read");
    endtask

    task automatic test_loops_waits();
        logic [7:0] prog [11] = '{8'h01, 8'h02, 8'h80, 8'hC2, 8'h81, 8'hE4, 8'h42, 8'h86,
            8'h53, 8'h87, 8'h03};
        periph.clear_counts();
        load(prog);
        wr(tscd_pkg::REG_LIM0, 16'h0002);
        wr(tscd_pkg::REG_LIM1, 16'h0001);
        periph.set_level(3, 1'b1, 0);
        wr(tscd_pkg::REG_CTRL, 16'h0002);
        wr(tscd_pkg::REG_CTRL, 16'h0001);
        tick(30);
        chk(periph.trig_cnt[0], 32'h3, "loop on counter 0");
        chk(periph.trig_cnt[1], 32'h2, "loop on counter 1");
        rchk(tscd_pkg::REG_STAT, 16'h0603, "waiting at step 6");
        periph.set_level(1, 1'b1, 0);
        tick(5);
        chk(periph.trig_cnt[6], 32'h0, "other input ignored");
        periph.set_level(2, 1'b1, 3);
        tick(5);
        chk(periph.trig_cnt[6], 32'h1, "released by rise");
        chk(periph.trig_cnt[7], 32'h0, "held for fall");
        periph.set_level(3, 1'b0, 7);
        tick(3);
        wait_idle();
        chk(periph.trig_cnt[7], 32'h1, "released by fall");
        rchk(tscd_pkg::REG_CNT0, 16'h0002, "counter 0 at limit");
        rchk(tscd_pkg::REG_CNT1, 16'h0001, "counter 1 at limit");
        rchk(tscd_pkg::REG_STAT, 16'h0B00, "halted after clears");
    endtask

    ////////////////////////////////////////////////////////////////////////////
    initial begin
        rst_b = 1'b0;
        wr_en = 1'b0;
        rd_en = 1'b0;
        addr = 6'h00;
        wdata = 16'h0000;
        repeat (5) @(posedge clk);
        rst_b <= 1'b1;
        test_actions();
        test_irq();
        test_loops_waits();
        give_verdict();
    end

    initial begin
        repeat (20000) @(posedge clk);
        bad_count++;
        give_verdict();
    end
endmodule

// ===== tscd_top.sv
// step queue, command decoder and executor of the trigger sequencer
// assumes register port strobes one cycle long and inputs synchronous to SYS_CLK_I
//
// The strobed register port and the placing of the registers were decided locally.
`timescale 1ns/100ps
module tscd_top (
    // clock and reset
    input wire logic SYS_CLK_I,
    input wire logic RST_B_I,
    // register port
    input wire logic [5:0] ADDR_I,
    input wire logic [15:0] WDATA_I,
    input wire logic WR_I,
    input wire logic RD_I,
    output logic [15:0] RDATA_O,
    // trigger inputs and outputs
    input wire logic [15:0] TRIG_IN_I,
    output logic [31:0] TRIG_OUT_O,
    // interrupt requests
    output logic [15:0] INT_REQ_O,
    output logic IRQ_O,
    // converter channel select
    output logic [4:0] CHAN_SEL_O
);

    ////////////////////////////////////////////////////////////////////////////
    // state

    typedef struct packed {
        tscd_pkg::tscd_state_t state;
        logic run;
        logic [4:0] qptr;
        logic [31:0][7:0] queue;
        logic [15:0] adj;
        logic [15:0] hold;
        logic [15:0] lim0;
        logic [15:0] lim1;
        logic [15:0] cnt0;
        logic [15:0] cnt1;
        logic [4:0] chsel;
        logic [31:0] trig;
        logic [15:0] int_req;
        logic [15:0] rdata;
    } tscd_regs_t;

    tscd_regs_t r;
    tscd_regs_t next_r;

    tscd_pkg::tscd_edge_t edges;
    tscd_pkg::tscd_irq_t irq;
    logic [15:0] irq_set;
    logic int_clr_wr;
    logic int_mask_wr;

    logic [7:0] step;
    logic [3:0] cmd;
    logic [3:0] opt;
    logic [15:0] operand;
    logic edge_hit;
    // five-bit target of strobe, trigger and jump steps
    logic [4:0] target;

    // register hit for a word offset outside the queue window
    function automatic logic reg_hit(input logic [5:0] addr, input logic [5:0] off);
        return (addr == off);
    endfunction

    // two-code commands share the upper three bits
    function automatic logic in_group(input logic [3:0] code, input logic [2:0] grp);
        return (code[3:1] == grp);
    endfunction

    ////////////////////////////////////////////////////////////////////////////
    // helpers

    tscd_edge_det tscd_edge_det_inst (
        .clk_i(SYS_CLK_I),
        .rst_b_i(RST_B_I),
        .trig_i(TRIG_IN_I),
        .edge_o(edges)
    );

    ////////////////////////////////////////////////////////////////////////////
    // interrupt status and mask

    // clear and mask writes go to the status block
    assign int_clr_wr = WR_I & reg_hit(ADDR_I, tscd_pkg::REG_INT_STAT);
    assign int_mask_wr = WR_I & reg_hit(ADDR_I, tscd_pkg::REG_INT_MASK);

    tscd_irq tscd_irq_inst (
        .clk_i(SYS_CLK_I),
        .rst_b_i(RST_B_I),
        .set_i(irq_set),
        .clr_wr_i(int_clr_wr),
        .mask_wr_i(int_mask_wr),
        .wdata_i(WDATA_I),
        .irq_o(irq)
    );

    ////////////////////////////////////////////////////////////////////////////
    // step decode

    assign step = r.queue[r.qptr];
    assign cmd = step[7:4];
    assign opt = step[3:0];
    assign target = tscd_pkg::target5(step);

    // add or copy source
    assign operand = opt[tscd_pkg::OPT_COPY_BIT] ? r.hold : r.adj;

    ////////////////////////////////////////////////////////////////////////////
    // wait steps

    // edge the current wait step is looking for
    always_comb begin
        edge_hit = 1'b0;
        if (cmd == tscd_pkg::CMD_WAIT_HI) begin
            edge_hit = edges.rise[opt];
        end else if (cmd == tscd_pkg::CMD_WAIT_LO) begin
            edge_hit = edges.fall[opt];
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // next state

    always_comb begin
        next_r = r;
        next_r.trig = 32'h0000_0000;
        next_r.int_req = 16'h0000;
        next_r.rdata = 16'h0000;
        irq_set = 16'h0000;

        // software writes
        if (WR_I) begin
            if (ADDR_I[tscd_pkg::QUEUE_SEL_BIT]) begin
                // a running queue sees it on the next visit
                next_r.queue[ADDR_I[4:0]] = WDATA_I[7:0];
            end else begin
                case (ADDR_I)
                    tscd_pkg::REG_CTRL: begin
                        next_r.run = WDATA_I[tscd_pkg::CTRL_RUN_BIT];
                        if (WDATA_I[tscd_pkg::CTRL_PTR_CLR_BIT]) begin
                            next_r.qptr = 5'h00;
                        end
                    end
                    tscd_pkg::REG_ADJ: begin
                        next_r.adj = WDATA_I;
                    end
                    tscd_pkg::REG_HOLD: begin
                        next_r.hold = WDATA_I;
                    end
                    tscd_pkg::REG_LIM0: begin
                        next_r.lim0 = WDATA_I;
                    end
                    tscd_pkg::REG_LIM1: begin
                        next_r.lim1 = WDATA_I;
                    end
                    tscd_pkg::REG_CNT0: begin
                        next_r.cnt0 = WDATA_I;
                    end
                    tscd_pkg::REG_CNT1: begin
                        next_r.cnt1 = WDATA_I;
                    end
                    tscd_pkg::REG_CHSEL: begin
                        next_r.chsel = WDATA_I[4:0];
                    end
                    default: begin
                    end
                endcase
            end
        end

        // software reads, answered next cycle
        if (RD_I) begin
            if (ADDR_I[tscd_pkg::QUEUE_SEL_BIT]) begin
                next_r.rdata = {8'h00, r.queue[ADDR_I[4:0]]};
            end else begin
                case (ADDR_I)
                    tscd_pkg::REG_CTRL: begin
                        next_r.rdata[tscd_pkg::CTRL_RUN_BIT] = r.run;
                    end
                    tscd_pkg::REG_STAT: begin
                        // busy, waiting and the pointer
                        next_r.rdata[tscd_pkg::STAT_BUSY_BIT] = (r.state != tscd_pkg::ST_IDLE);
                        next_r.rdata[tscd_pkg::STAT_WAIT_BIT] = (r.state == tscd_pkg::ST_WAIT);
                        next_r.rdata[tscd_pkg::STAT_PTR_LSB +: 5] = r.qptr;
                    end
                    tscd_pkg::REG_ADJ: begin
                        next_r.rdata = r.adj;
                    end
                    tscd_pkg::REG_HOLD: begin
                        next_r.rdata = r.hold;
                    end
                    tscd_pkg::REG_LIM0: begin
                        next_r.rdata = r.lim0;
                    end
                    tscd_pkg::REG_LIM1: begin
                        next_r.rdata = r.lim1;
                    end
                    tscd_pkg::REG_CNT0: begin
                        next_r.rdata = r.cnt0;
                    end
                    tscd_pkg::REG_CNT1: begin
                        next_r.rdata = r.cnt1;
                    end
                    tscd_pkg::REG_CHSEL: begin
                        next_r.rdata = {11'h000, r.chsel};
                    end
                    tscd_pkg::REG_INT_STAT: begin
                        next_r.rdata = irq.status;
                    end
                    tscd_pkg::REG_INT_MASK: begin
                        next_r.rdata = irq.mask;
                    end
                    default: begin
                        // unmapped words read as zero
                        next_r.rdata = 16'h0000;
                    end
                endcase
            end
        end

        // step execution; overrides a software write to the same field
        case (r.state)
            tscd_pkg::ST_IDLE: begin
                // resume at the pointer left by the last run
                if (r.run) begin
                    next_r.state = tscd_pkg::ST_EXEC;
                end
            end
            // run cleared mid-queue stops at the step boundary
            tscd_pkg::ST_EXEC: begin
                if (!r.run) begin
                    next_r.state = tscd_pkg::ST_IDLE;
                end else begin
                    // one step a cycle; pointer wraps from 31 to 0
                    next_r.qptr = r.qptr + 5'h01;
                    if (cmd == tscd_pkg::CMD_CTRL) begin
                        case (opt)
                            tscd_pkg::CTL_NOP: begin
                                // only the pointer moves
                            end
                            tscd_pkg::CTL_CLR_C0: begin
                                next_r.cnt0 = 16'h0000;
                            end
                            tscd_pkg::CTL_CLR_C1: begin
                                next_r.cnt1 = 16'h0000;
                            end
                            tscd_pkg::CTL_HALT: begin
                                // pointer stays past the halt step
                                next_r.run = 1'b0;
                                next_r.state = tscd_pkg::ST_IDLE;
                            end
                            default: begin
                                // reserved options 4 to 15
                            end
                        endcase
                    end else if (cmd == tscd_pkg::CMD_ADD) begin
                        case (opt[2:0])
                            tscd_pkg::TGT_LIM0: begin
                                next_r.lim0 = opt[3] ? operand : r.lim0 + operand;
                            end
                            tscd_pkg::TGT_LIM1: begin
                                next_r.lim1 = opt[3] ? operand : r.lim1 + operand;
                            end
                            tscd_pkg::TGT_CNT0: begin
                                next_r.cnt0 = opt[3] ? operand : r.cnt0 + operand;
                            end
                            tscd_pkg::TGT_CNT1: begin
                                next_r.cnt1 = opt[3] ? operand : r.cnt1 + operand;
                            end
                            default: begin
                                // reserved targets
                            end
                        endcase
                    end else if (in_group(cmd, tscd_pkg::GRP_STRB)) begin
                        next_r.chsel = target;
                    end else if (cmd == tscd_pkg::CMD_WAIT_HI
                                 || cmd == tscd_pkg::CMD_WAIT_LO) begin
                        next_r.qptr = r.qptr;
                        next_r.state = tscd_pkg::ST_WAIT;
                    end else if (cmd == tscd_pkg::CMD_IRQ) begin
                        next_r.int_req[opt] = 1'b1;
                        irq_set[opt] = 1'b1;
                    end else if (in_group(cmd, tscd_pkg::GRP_TRIG)) begin
                        next_r.trig[target] = 1'b1;
                    end else if (in_group(cmd, tscd_pkg::GRP_JMP)) begin
                        next_r.qptr = target;
                    end else if (in_group(cmd, tscd_pkg::GRP_JC0)) begin
                        // at the limit the counter holds and the pointer advances
                        if (r.cnt0 != r.lim0) begin
                            next_r.cnt0 = r.cnt0 + 16'h0001;
                            next_r.qptr = target;
                        end
                    end else if (in_group(cmd, tscd_pkg::GRP_JC1)) begin
                        if (r.cnt1 != r.lim1) begin
                            next_r.cnt1 = r.cnt1 + 16'h0001;
                            next_r.qptr = target;
                        end
                    end else if (cmd == tscd_pkg::CMD_RSVD) begin
                        // reserved code 0110
                    end else begin
                        // all codes decoded above
                    end
                end
            end
            // an edge in the cycle that enters the wait is missed
            tscd_pkg::ST_WAIT: begin
                if (!r.run) begin
                    next_r.state = tscd_pkg::ST_IDLE;
                end else if (edge_hit) begin
                    next_r.qptr = r.qptr + 5'h01;
                    next_r.state = tscd_pkg::ST_EXEC;
                end
            end
            default: begin
                next_r.state = tscd_pkg::ST_IDLE;
            end
        endcase
    end

    ////////////////////////////////////////////////////////////////////////////
    // registers

    always_ff @(posedge SYS_CLK_I or negedge RST_B_I) begin
        if (!RST_B_I) begin
            r <= '0;
        end else begin
            r <= next_r;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // outputs

    // the interrupt level is a flop inside its block
    assign RDATA_O = r.rdata;
    assign TRIG_OUT_O = r.trig;
    assign INT_REQ_O = r.int_req;
    assign CHAN_SEL_O = r.chsel;
    assign IRQ_O = irq.irq;

endmodule
